/* File: bench/mem_ctrl_model.sv */
// Memory controller model driving the bus pins of the config logic.
// Assumes the bench clock clk; pins change on its falling edge.
`timescale 1ns/1ns
module mem_ctrl_model
    import psram_cfg_pkg::*;
(
    input wire logic clk,
    output logic linkClk,
    output logic ceN,
    output logic advN,
    output logic weN,
    output logic oeN,
    output logic registerSelectPin,
    output logic swLoadReq,
    output word_addr_t addrIn,
    output cfg_word_t dqIn,
    input wire cfg_word_t dqOut,
    input wire logic dqOe
);
    // Idle bus, link clock parked low outside bursts
    initial begin
        {linkClk, swLoadReq, registerSelectPin} = 3'h0;
        {ceN, advN, weN, oeN} = 4'hf;
        addrIn = 20'h5a5a5;
        dqIn = 16'ha5a5;
    end
    // Load via select pin; weN low well past the input sync
    task automatic pin_write(input word_addr_t a);
        @(negedge clk);
        addrIn = a;
        registerSelectPin = 1'b1;
        ceN = 1'b0;
        @(negedge clk);
        weN = 1'b0;
        repeat (6) @(negedge clk);
        weN = 1'b1;
        repeat (4) @(negedge clk);
        ceN = 1'b1;
        registerSelectPin = 1'b0;
        addrIn = ~a;
        repeat (4) @(negedge clk);
    endtask
    // Read back via select pin, sampled while the request still stands
    task automatic pin_read(input word_addr_t a, output cfg_word_t q,
        output logic oe);
        @(negedge clk);
        addrIn = a;
        registerSelectPin = 1'b1;
        ceN = 1'b0;
        oeN = 1'b0;
        repeat (5) @(negedge clk);
        q = dqOut;
        oe = dqOe;
        oeN = 1'b1;
        ceN = 1'b1;
        registerSelectPin = 1'b0;
        addrIn = ~a;
        repeat (4) @(negedge clk);
    endtask
    // Software load, select word on dqIn, released lines inverted
    task automatic sw_load(input word_addr_t a, input cfg_word_t sel);
        @(negedge clk);
        addrIn = a;
        dqIn = sel;
        @(negedge clk);
        swLoadReq = 1'b1;
        repeat (6) @(negedge clk);
        swLoadReq = 1'b0;
        addrIn = ~a;
        dqIn = ~sel;
        repeat (4) @(negedge clk);
    endtask
    // Burst of n link periods of 320 ns, well under the 53 MHz limit
    task automatic burst(input word_addr_t a, input logic wr, input int n);
        @(negedge clk);
        ceN = 1'b0;
        advN = 1'b0;
        weN = ~wr;
        addrIn = a;
        for (int i = 0; i < n; i++) begin
            repeat (4) @(negedge clk);
            linkClk = 1'b1;
            repeat (4) @(negedge clk);
            linkClk = 1'b0;
            advN = 1'b1;
            addrIn = ~addrIn;
        end
        repeat (4) @(negedge clk);
    endtask
    // Close the burst
    task automatic burst_end();
        ceN = 1'b1;
        weN = 1'b1;
        repeat (8) @(negedge clk);
    endtask
endmodule

/* File: bench/tb_psram_burst_refresh_config_regs.sv */
// Self-checking bench for the configuration register logic.
// Assumes the controller model drives every DUT input except clk and rst.
`timescale 1ns/1ns
`include "psram_cfg.svh"
module tb_psram_burst_refresh_config_regs
    import psram_cfg_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic linkClk, ceN, advN, weN, oeN, registerSelectPin, swLoadReq;
    word_addr_t addrIn, arrayAddr, refreshStart, refreshEnd, a;
    cfg_word_t dqIn, busCfgOut, refCfgOut, d, r;
    logic waitOut, arrayStrobe, driveReduced, syncMode, pageModeEn;
    logic deepSleepMode, initBusy, tempSensorEn, refreshNone;
    logic latencyRejected;
    cfg_word_t dqOut, q;
    logic dqOe, qe, waitOe, dataValid, arrayWrite, wrSeen;
    logic [39:0] pb;
    logic [1:0] fixedRateSel;
    word_addr_t seen[$];
    int err_total = 0;
    int compares = 0;
    int busyCnt = 0;
    int n;
    // 25 MHz clock
    always #20 clk = ~clk;
    mem_ctrl_model ctl(.clk(clk), .linkClk(linkClk), .ceN(ceN),
        .advN(advN), .weN(weN), .oeN(oeN),
        .registerSelectPin(registerSelectPin), .swLoadReq(swLoadReq),
        .addrIn(addrIn), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe));
    psram_cfg_regs #(.INIT_CYCLES(12'd20)) DUT(.clk(clk), .rst(rst),
        .linkClk(linkClk), .ceN(ceN), .advN(advN), .weN(weN), .oeN(oeN),
        .registerSelectPin(registerSelectPin), .swLoadReq(swLoadReq),
        .addrIn(addrIn), .dqIn(dqIn), .dqOut(dqOut), .dqOe(dqOe),
        .waitOut(waitOut), .waitOe(waitOe), .arrayAddr(arrayAddr),
        .arrayStrobe(arrayStrobe), .arrayWrite(arrayWrite),
        .dataValid(dataValid), .driveReduced(driveReduced),
        .syncMode(syncMode), .pageModeEn(pageModeEn),
        .deepSleepMode(deepSleepMode), .initBusy(initBusy),
        .tempSensorEn(tempSensorEn), .fixedRateSel(fixedRateSel),
        .refreshNone(refreshNone), .refreshStart(refreshStart),
        .refreshEnd(refreshEnd), .latencyRejected(latencyRejected),
        .busCfgOut(busCfgOut), .refCfgOut(refCfgOut));
    // Collect burst word addresses and time the wake-up
    always @(negedge clk) begin
        if (arrayStrobe === 1'b1) begin
            seen.push_back(arrayAddr);
            wrSeen = arrayWrite;
        end
        if (initBusy === 1'b1)
            busyCnt++;
    end
    task automatic chk(input string nm, input logic [19:0] e,
        input logic [19:0] g);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic end_of_test();
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Sync mode, latency code 2, wait polarity from pol, wait early
    function automatic cfg_word_t bus_val(input logic [2:0] len,
        input logic lin, input logic pol);
        return 16'h1100 | (16'(pol) << 10) | (16'(lin) << 3) | 16'(len);
    endfunction
    // Partition bounds as {start, end}
    function automatic logic [39:0] part(input logic [2:0] c);
        case (c)
            3'h1: return {20'h00000, 20'h7ffff};
            3'h2: return {20'h00000, 20'h3ffff};
            3'h3: return {20'h00000, 20'h1ffff};
            3'h5: return {20'h80000, 20'hfffff};
            3'h6: return {20'hc0000, 20'hfffff};
            3'h7: return {20'he0000, 20'hfffff};
            default: return {20'h00000, 20'hfffff};
        endcase
    endfunction
    // Hang guard
    initial begin
        #3000000;
        err_total++;
        end_of_test();
    end
    initial begin
        d = 16'($urandom(67024));
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk("bus", 20'h09d4f, busCfgOut);
        chk("ref", 20'h00010, refCfgOut);
        chk("page", 0, pageModeEn);
        chk("sensor", 1, tempSensorEn);
        chk("sync", 0, syncMode);
        for (int i = 0; i < 4; i++) begin
            d = 16'($urandom);
            d[13:11] = {2'b01, d[0]};
            ctl.pin_write({4'h8, d});
            chk("bus", d, busCfgOut);
            chk("drive", d[5], driveReduced);
            chk("rej", 0, latencyRejected);
        end
        r = d;
        r[13:11] = 3'h4 | 3'(i_rand());
        ctl.pin_write({4'h8, r});
        chk("bus", {r[15:14], d[13:11], r[10:0]}, busCfgOut);
        chk("rej", 1, latencyRejected);
        for (int i = 0; i < 8; i++) begin
            r = 16'h0010 | (16'(i >> 2) << 7) | (16'(i & 3) << 5) | 16'(i);
            ctl.pin_write(20'(r));
            chk("ref", r, refCfgOut);
            chk("rate", i & 3, fixedRateSel);
            chk("sensor", (i & 3) == 0, tempSensorEn);
            chk("page", r[7], pageModeEn);
            chk("none", i == 4, refreshNone);
            pb = part(3'(i));
            if (i != 4) begin
                chk("pstart", pb[39:20], refreshStart);
                chk("pend", pb[19:0], refreshEnd);
            end
        end
        ctl.sw_load(20'h01d4f, `SW_SEL_BUS);
        chk("bus", 20'h01d4f, busCfgOut);
        chk("rej", 0, latencyRejected);
        ctl.pin_read(20'h80000, q, qe);
        chk("rdbus", 20'h01d4f, q);
        chk("rdoe", 1, qe);
        chk("rdoff", 0, dqOe);
        ctl.sw_load(20'h00003, `SW_SEL_REF);
        chk("ref", 20'h00013, refCfgOut);
        ctl.pin_read(20'h00000, q, qe);
        chk("rdref", 20'h00013, q);
        ctl.sw_load(20'h00081, 16'h0002);
        chk("ref", 20'h00013, refCfgOut);
        ctl.pin_write(20'h00000);
        chk("sleep", 1, deepSleepMode);
        busyCnt = 0;
        ctl.pin_write(20'h00010);
        repeat (30) @(negedge clk);
        chk("sleep", 0, deepSleepMode);
        chk("initlen", 20, busyCnt);
        for (int k = 0; k < 3; k++) begin
            n = 4 << k;
            a = 20'($urandom);
            ctl.pin_write({4'h8, bus_val(3'(k + 1), 0, k[0])});
            seen.delete();
            ctl.burst(a, 0, n + 5);
            chk("wait", k[0], waitOut);
            chk("waitoe", 1, waitOe);
            ctl.burst_end();
            chk("count", n, seen.size());
            for (int j = 0; j < n; j++)
                chk("waddr", (a & ~(n - 1)) | ((a + j) & (n - 1)),
                    seen[j]);
        end
        chk("wrflag", 0, wrSeen);
        ctl.pin_write({4'h8, bus_val(3'h7, 1'b1, 1'b1) | 16'h0800});
        seen.delete();
        ctl.burst(20'hfffff, 1'b0, 6);
        chk("valid", 1, dataValid);
        ctl.burst_end();
        chk("lat4", 2, seen.size());
        chk("roll0", 20'hfffff, seen[0]);
        chk("roll1", 20'h00000, seen[1]);
        ctl.pin_write({4'h8, bus_val(3'h1, 1'b0, 1'b1) & 16'hfeff});
        seen.delete();
        ctl.burst(20'h00010, 1'b1, 12);
        chk("wait", 0, waitOut);
        ctl.burst_end();
        chk("wrlen", 1, seen.size() > 4);
        chk("wrflag", 1, wrSeen);
        ctl.pin_write({4'h8, 16'h8000 | bus_val(3'h1, 0, 1)});
        seen.delete();
        ctl.burst(20'h00010, 0, 10);
        ctl.burst_end();
        chk("async", 0, seen.size());
        end_of_test();
    end
    // Random pick of an illegal latency low bits
    function automatic int i_rand();
        return $urandom % 4;
    endfunction
endmodule

/* File: design/burst_next_addr.sv */
// Next word address of a burst, with wrap inside the burst block.
// Assumes a combinational caller that registers the result.
`timescale 1ns/1ns
`include "psram_cfg.svh"

module burst_next_addr
    import psram_cfg_pkg::*;
#(
    parameter logic [2:0] LEN4_CODE = `LEN_CODE_4,
    parameter logic [2:0] LEN8_CODE = `LEN_CODE_8,
    parameter logic [2:0] LEN16_CODE = `LEN_CODE_16
) (
    input wire logic [2:0] lenCode,
    input wire logic wrapEn,
    input wire word_addr_t addr,
    output word_addr_t nextAddr,
    output logic [3:0] lastIndex,
    output logic continuous
);

    word_addr_t incr;
    word_addr_t mask;

    // Burst length decode, unknown codes run continuous
    always_comb begin
        continuous = 1'b0;
        lastIndex = 4'hf;
        case (lenCode)
            LEN4_CODE: lastIndex = 4'h3;
            LEN8_CODE: lastIndex = 4'h7;
            LEN16_CODE: lastIndex = 4'hf;
            default: continuous = 1'b1;
        endcase
    end

    // Wrap inside the aligned block, else linear with rollover to zero
    always_comb begin
        incr = addr + 20'h00001;
        mask = {16'h0000, lastIndex};
        if (wrapEn && !continuous) begin
            nextAddr = (addr & ~mask) | (incr & mask);
        end else begin
            nextAddr = incr;
        end
    end

endmodule

/* File: design/psram_cfg.svh */
// Bit positions, reset values, codes and timing counts shared by the
// configuration register logic and its burst address stepper.
// Assumes inclusion by bare name from files under design/.
`ifndef PSRAM_CFG_SVH
`define PSRAM_CFG_SVH

// Reset values
`define BUS_CFG_RESET 16'h9d4f
`define REF_CFG_RESET 16'h0010

// Bus configuration fields
`define BUS_LEN_MSB 2
`define BUS_LEN_LSB 0
`define BUS_WRAP_BIT 3
`define BUS_DRIVE_BIT 5
`define BUS_WAITCFG_BIT 8
`define BUS_WAITPOL_BIT 10
`define BUS_LAT_MSB 13
`define BUS_LAT_LSB 11
`define BUS_MODE_BIT 15

// Refresh configuration fields
`define REF_PART_MSB 2
`define REF_PART_LSB 0
`define REF_SLEEP_BIT 4
`define REF_TEMP_MSB 6
`define REF_TEMP_LSB 5
`define REF_PAGE_BIT 7

// Latency codes that are accepted
`define LAT_CODE_3CLK 3'h2
`define LAT_CODE_4CLK 3'h3

// Burst length codes
`define LEN_CODE_4 3'h1
`define LEN_CODE_8 3'h2
`define LEN_CODE_16 3'h3
`define LEN_CODE_CONT 3'h7

// Third-cycle data of the software load sequence
`define SW_SEL_REF 16'h0000
`define SW_SEL_BUS 16'h0001

// Refresh rate selections
`define TEMP_SENSOR 2'h0
`define TEMP_15C 2'h2
`define TEMP_45C 2'h1
`define TEMP_85C 2'h3

// Refresh partition codes and bounds
`define PART_FULL 3'h0
`define PART_HALF_LO 3'h1
`define PART_QUART_LO 3'h2
`define PART_EIGHTH_LO 3'h3
`define PART_NONE 3'h4
`define PART_HALF_HI 3'h5
`define PART_QUART_HI 3'h6
`define PART_EIGHTH_HI 3'h7
`define ADDR_BOTTOM 20'h00000
`define ADDR_TOP 20'hfffff
`define HALF_LO_END 20'h7ffff
`define QUART_LO_END 20'h3ffff
`define EIGHTH_LO_END 20'h1ffff
`define HALF_HI_START 20'h80000
`define QUART_HI_START 20'hc0000
`define EIGHTH_HI_START 20'he0000

// Wake-up initialisation time
`define INIT_TIME_US 150
`define CLK_FREQ_MHZ 25
`define INIT_CYCLES (`INIT_TIME_US * `CLK_FREQ_MHZ)

`endif

/* File: design/psram_cfg_pkg.sv */
// Types shared by the configuration register logic.
// Assumes nothing beyond a SystemVerilog compiler.
package psram_cfg_pkg;

    // Burst engine states, Gray coded along idle-latency-transfer-end
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LATENCY = 2'b01,
        ST_XFER = 2'b11,
        ST_END = 2'b10
    } burst_state_t;

    typedef logic [15:0] cfg_word_t;
    typedef logic [19:0] word_addr_t;

endpackage

/* File: design/psram_cfg_regs.sv */
// Configuration registers and synchronous burst sequencing of a pseudo
// static memory. Assumes bus pins arrive asynchronously to clk and the
// memory bus clock is far slower than clk.
`timescale 1ns/1ns
`include "psram_cfg.svh"

module psram_cfg_regs
    import psram_cfg_pkg::*;
#(
    parameter logic [2:0] LEN4_CODE = `LEN_CODE_4,
    parameter logic [2:0] LEN8_CODE = `LEN_CODE_8,
    parameter logic [2:0] LEN16_CODE = `LEN_CODE_16,
    parameter logic [11:0] INIT_CYCLES = 12'(`INIT_CYCLES)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic linkClk,
    input wire logic ceN,
    input wire logic advN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic registerSelectPin,
    input wire logic swLoadReq,
    input wire word_addr_t addrIn,
    input wire cfg_word_t dqIn,
    output cfg_word_t dqOut,
    output logic dqOe,
    output logic waitOut,
    output logic waitOe,
    output word_addr_t arrayAddr,
    output logic arrayStrobe,
    output logic arrayWrite,
    output logic dataValid,
    output logic driveReduced,
    output logic syncMode,
    output logic pageModeEn,
    output logic deepSleepMode,
    output logic initBusy,
    output logic tempSensorEn,
    output logic [1:0] fixedRateSel,
    output logic refreshNone,
    output word_addr_t refreshStart,
    output word_addr_t refreshEnd,
    output logic latencyRejected,
    output cfg_word_t busCfgOut,
    output cfg_word_t refCfgOut
);

    localparam logic [42:0] SYNC_IDLE = {7'b0111100, 36'h0};

    logic [42:0] syncA_r;
    logic [42:0] syncB_r;
    logic linkPrev_r;
    logic wePrev_r;
    logic swPrev_r;
    logic linkS, ceNs, advNs, weNs, oeNs, creS, swS;
    word_addr_t addrS;
    cfg_word_t dqS;
    logic linkTick, creWrite, swWrite, busWrite, refWrite, latOk;
    cfg_word_t newVal;
    cfg_word_t busCfg_r;
    cfg_word_t refCfg_r;
    logic latRej_r;
    logic [11:0] initCnt_r;
    logic engineEn;
    burst_state_t state_r;
    logic [2:0] latCnt_r;
    logic [3:0] wordCnt_r;
    logic isWrite_r;
    word_addr_t addr_r;
    word_addr_t nextAddr;
    logic [3:0] lastIndex;
    logic continuous;
    logic lastLat, lastWord, waitAct;
    logic waitOut_r, waitOe_r, dqOe_r, strobe_r, arrayWrite_r;
    cfg_word_t dqOut_r;
    word_addr_t arrayAddr_r, refStart_r, refEnd_r;
    logic refNone_r;

    // Two-stage synchroniser for every bus pin
    always_ff @(posedge clk) begin
        if (rst) begin
            syncA_r <= SYNC_IDLE;
            syncB_r <= SYNC_IDLE;
        end else begin
            syncA_r <= {linkClk, ceN, advN, weN, oeN, registerSelectPin,
                        swLoadReq, addrIn, dqIn};
            syncB_r <= syncA_r;
        end
    end

    assign {linkS, ceNs, advNs, weNs, oeNs, creS, swS, addrS, dqS} = syncB_r;

    // Previous levels for edge detection
    always_ff @(posedge clk) begin
        if (rst) begin
            linkPrev_r <= 1'b0;
            wePrev_r <= 1'b1;
            swPrev_r <= 1'b0;
        end else begin
            linkPrev_r <= linkS;
            wePrev_r <= weNs;
            swPrev_r <= swS;
        end
    end

    // Register selection: select pin with A19, or software sequence
    assign linkTick = linkS && !linkPrev_r;
    assign creWrite = creS && !ceNs && !weNs && wePrev_r;
    assign swWrite = swS && !swPrev_r && !creS
                     && (dqS == `SW_SEL_BUS || dqS == `SW_SEL_REF);
    assign busWrite = (creWrite && addrS[19])
                      || (swWrite && dqS == `SW_SEL_BUS);
    assign refWrite = (creWrite && !addrS[19])
                      || (swWrite && dqS == `SW_SEL_REF);
    assign newVal = addrS[15:0];
    assign latOk = newVal[`BUS_LAT_MSB:`BUS_LAT_LSB] == `LAT_CODE_3CLK
                   || newVal[`BUS_LAT_MSB:`BUS_LAT_LSB] == `LAT_CODE_4CLK;

    // Bus configuration register, illegal latency keeps old field
    always_ff @(posedge clk) begin
        if (rst) begin
            busCfg_r <= `BUS_CFG_RESET;
            latRej_r <= 1'b0;
        end else if (busWrite) begin
            latRej_r <= !latOk;
            if (latOk) begin
                busCfg_r <= newVal;
            end else begin
                busCfg_r <= {newVal[15:14],
                             busCfg_r[`BUS_LAT_MSB:`BUS_LAT_LSB],
                             newVal[10:0]};
            end
        end
    end

    // Refresh configuration, software path cannot touch the sleep bit
    always_ff @(posedge clk) begin
        if (rst) begin
            refCfg_r <= `REF_CFG_RESET;
        end else if (refWrite) begin
            if (creWrite) begin
                refCfg_r <= newVal;
            end else begin
                refCfg_r <= {newVal[15:5], refCfg_r[`REF_SLEEP_BIT],
                             newVal[3:0]};
            end
        end
    end

    // Wake-up initialisation counter after deep sleep exit
    always_ff @(posedge clk) begin
        if (rst) begin
            initCnt_r <= 12'h000;
        end else if (creWrite && !addrS[19] && !refCfg_r[`REF_SLEEP_BIT]
                     && newVal[`REF_SLEEP_BIT]) begin
            initCnt_r <= INIT_CYCLES;
        end else if (initCnt_r != 12'h000) begin
            initCnt_r <= initCnt_r - 12'h001;
        end
    end

    // Burst engine runs only in synchronous mode while awake
    assign engineEn = !busCfg_r[`BUS_MODE_BIT]
                      && refCfg_r[`REF_SLEEP_BIT]
                      && initCnt_r == 12'h000;

    burst_next_addr #(
        .LEN4_CODE(LEN4_CODE),
        .LEN8_CODE(LEN8_CODE),
        .LEN16_CODE(LEN16_CODE)
    ) u_step (
        .lenCode(isWrite_r ? `LEN_CODE_CONT
                           : busCfg_r[`BUS_LEN_MSB:`BUS_LEN_LSB]),
        .wrapEn(!busCfg_r[`BUS_WRAP_BIT]),
        .addr(addr_r),
        .nextAddr(nextAddr),
        .lastIndex(lastIndex),
        .continuous(continuous)
    );

    // Latency ends when the count reaches the code, start edge counted
    assign lastLat = latCnt_r == busCfg_r[`BUS_LAT_MSB:`BUS_LAT_LSB];
    assign lastWord = !continuous && wordCnt_r == lastIndex;

    // Burst sequencing on memory bus clock edges
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            latCnt_r <= 3'h0;
            wordCnt_r <= 4'h0;
            isWrite_r <= 1'b0;
            addr_r <= 20'h00000;
        end else if (ceNs) begin
            state_r <= ST_IDLE;
        end else if (linkTick) begin
            case (state_r)
                ST_IDLE: begin
                    if (!advNs && !creS && engineEn) begin
                        addr_r <= addrS;
                        isWrite_r <= !weNs;
                        latCnt_r <= 3'h1;
                        wordCnt_r <= 4'h0;
                        state_r <= ST_LATENCY;
                    end
                end
                ST_LATENCY: begin
                    if (lastLat) begin
                        state_r <= ST_XFER;
                    end else begin
                        latCnt_r <= latCnt_r + 3'h1;
                    end
                end
                ST_XFER: begin
                    addr_r <= nextAddr;
                    wordCnt_r <= wordCnt_r + 4'h1;
                    if (lastWord) begin
                        state_r <= ST_END;
                    end
                end
                ST_END: state_r <= ST_END;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Wait timing: early mode leads data by one bus clock
    always_comb begin
        if (busCfg_r[`BUS_WAITCFG_BIT]) begin
            waitAct = (state_r == ST_LATENCY && !lastLat)
                      || state_r == ST_END
                      || (state_r == ST_XFER && lastWord);
        end else begin
            waitAct = state_r == ST_LATENCY
                      || state_r == ST_END;
        end
    end

    // Wait pin with programmable polarity, driven while selected
    always_ff @(posedge clk) begin
        if (rst) begin
            waitOut_r <= 1'b0;
            waitOe_r <= 1'b0;
        end else begin
            waitOut_r <= busCfg_r[`BUS_WAITPOL_BIT] ? waitAct
                                                    : !waitAct;
            waitOe_r <= !ceNs;
        end
    end

    // Array access strobe for each transferred word
    always_ff @(posedge clk) begin
        if (rst) begin
            strobe_r <= 1'b0;
            arrayWrite_r <= 1'b0;
            arrayAddr_r <= 20'h00000;
        end else begin
            strobe_r <= linkTick && !ceNs && state_r == ST_XFER;
            if (linkTick && !ceNs && state_r == ST_XFER) begin
                arrayAddr_r <= addr_r;
                arrayWrite_r <= isWrite_r;
            end
        end
    end

    // Configuration read-back on the data pins
    always_ff @(posedge clk) begin
        if (rst) begin
            dqOut_r <= 16'h0000;
            dqOe_r <= 1'b0;
        end else begin
            dqOut_r <= addrS[19] ? busCfg_r : refCfg_r;
            dqOe_r <= creS && !ceNs && weNs && !oeNs;
        end
    end

    // Refresh partition bounds
    always_ff @(posedge clk) begin
        if (rst) begin
            refStart_r <= `ADDR_BOTTOM;
            refEnd_r <= `ADDR_TOP;
            refNone_r <= 1'b0;
        end else begin
            refNone_r <= 1'b0;
            refStart_r <= `ADDR_BOTTOM;
            refEnd_r <= `ADDR_TOP;
            case (refCfg_r[`REF_PART_MSB:`REF_PART_LSB])
                `PART_FULL: refEnd_r <= `ADDR_TOP;
                `PART_HALF_LO: refEnd_r <= `HALF_LO_END;
                `PART_QUART_LO: refEnd_r <= `QUART_LO_END;
                `PART_EIGHTH_LO: refEnd_r <= `EIGHTH_LO_END;
                `PART_NONE: refNone_r <= 1'b1;
                `PART_HALF_HI: refStart_r <= `HALF_HI_START;
                `PART_QUART_HI: refStart_r <= `QUART_HI_START;
                `PART_EIGHTH_HI: refStart_r <= `EIGHTH_HI_START;
                default: refNone_r <= 1'b0;
            endcase
        end
    end

    // Mode outputs straight from the registers
    assign driveReduced = busCfg_r[`BUS_DRIVE_BIT];
    assign syncMode = !busCfg_r[`BUS_MODE_BIT];
    assign pageModeEn = refCfg_r[`REF_PAGE_BIT];
    assign deepSleepMode = !refCfg_r[`REF_SLEEP_BIT];
    assign initBusy = initCnt_r != 12'h000;
    assign tempSensorEn = refCfg_r[`REF_TEMP_MSB:`REF_TEMP_LSB]
                          == `TEMP_SENSOR;
    assign fixedRateSel = refCfg_r[`REF_TEMP_MSB:`REF_TEMP_LSB];
    assign refreshNone = refNone_r;
    assign refreshStart = refStart_r;
    assign refreshEnd = refEnd_r;
    assign latencyRejected = latRej_r;
    assign busCfgOut = busCfg_r;
    assign refCfgOut = refCfg_r;
    assign dqOut = dqOut_r;
    assign dqOe = dqOe_r;
    assign waitOut = waitOut_r;
    assign waitOe = waitOe_r;
    assign arrayAddr = arrayAddr_r;
    assign arrayStrobe = strobe_r;
    assign arrayWrite = arrayWrite_r;
    assign dataValid = state_r == ST_XFER;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reset_vals_a: assert property ($past(rst) |->
        busCfg_r == 16'h9d4f && refCfg_r == 16'h0010)
        else $error("configuration reset values wrong");
    lat_legal_a: assert property (
        busCfg_r[13:11] == 3'h2 || busCfg_r[13:11] == 3'h3)
        else $error("latency field holds an illegal code");
    lat_reject_a: assert property (busWrite && !latOk |=>
        latRej_r && busCfg_r[13:11] == $past(busCfg_r[13:11]))
        else $error("illegal latency not rejected");
    sw_sleep_a: assert property (refWrite && !creWrite |=>
        refCfg_r[4] == $past(refCfg_r[4]))
        else $error("software path changed deep sleep bit");
    init_start_a: assert property ($rose(refCfg_r[4]) |->
        initCnt_r == INIT_CYCLES ##1 initBusy[*8])
        else $error("wake-up initialisation not started");
    wrap_block_a: assert property (linkTick && !ceNs && !isWrite_r
        && state_r == ST_XFER && !busCfg_r[3] && !continuous
        |=> addr_r[19:4] == $past(addr_r[19:4]))
        else $error("wrapped burst left its block");
    linear_step_a: assert property (linkTick && !ceNs
        && state_r == ST_XFER && busCfg_r[3]
        |=> addr_r == $past(addr_r) + 20'h00001)
        else $error("linear burst did not step by one");
    write_cont_a: assert property (linkTick && !ceNs
        && state_r == ST_XFER && isWrite_r |=> state_r == ST_XFER)
        else $error("write burst ended on its own");
    burst_end_a: assert property (linkTick && !ceNs
        && state_r == ST_XFER && lastWord |=> state_r == ST_END)
        else $error("fixed burst overran its length");
    wait_early_a: assert property (state_r == ST_LATENCY && lastLat
        && busCfg_r[8] && busCfg_r[10] && !linkTick && !ceNs
        |=> !waitOut_r)
        else $error("wait did not lead data by one clock");
    wait_late_a: assert property (state_r == ST_LATENCY
        && !busCfg_r[8] && busCfg_r[10] && !linkTick && !ceNs
        |=> waitOut_r)
        else $error("wait released before data valid");
    part_high_a: assert property (refCfg_r[2:0] == 3'h5
        ##1 refCfg_r[2:0] == 3'h5 |-> refStart_r == 20'h80000
        && refEnd_r == 20'hfffff)
        else $error("upper half partition bounds wrong");

    burst_done_c: cover property (state_r == ST_XFER ##1 state_r == ST_END);
    wake_c: cover property ($rose(refCfg_r[4]));
    lat_rej_c: cover property (busWrite && !latOk);

endmodule
